// ==== verilog/crystal_trim_temp_comp_ctrl.sv ====
// Crystal trim and temperature compensation control registers and trim select.
// Assumes the serial port engine presents single-cycle read and write strobes
// and that the battery monitor and compensation arithmetic sit outside.
`timescale 1ns/1ns

module crystal_trim_temp_comp_ctrl import trim_ctrl_pkg::*; #(
	parameter longint unsigned SLOW_CYC = SLOW_PERIOD_CYC,
	parameter longint unsigned FAST_CYC = FAST_PERIOD_CYC
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in, // Register offset
	input wire logic [7:0] reg_wdata_in, // Write data
	input wire logic reg_wr_in, // Write strobe
	input wire logic reg_rd_in, // Read strobe
	output logic [7:0] reg_rdata_out, // Read data, one cycle after strobe
	input wire logic on_battery_in, // Running from the battery
	input wire logic vbat_low_in, // Battery below 2.6 V
	input wire logic [5:0] comp_analog_trim_in, // Compensated analog trim
	input wire logic [1:0] comp_digital_trim_in, // Compensated digital trim
	output logic comp_active_out, // Sensing and correction running
	output logic convert_req_out, // Battery-mode conversion pulse
	output logic [6:0] curvature_out, // Coefficient for the arithmetic
	output logic [3:0] step_gain_out, // Analog step gain for the arithmetic
	output logic [5:0] analog_trim_out, // Analog trim applied to oscillator
	output logic [1:0] digital_trim_out, // Digital trim code applied
	output logic signed [6:0] analog_offset_ppm_out, // Analog offset in ppm
	output logic signed [6:0] digital_offset_ppm_out, // Digital offset in ppm
	output logic digital_trim_enable_out // Pulse skip or insert allowed
);

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	// Analog code to signed ppm: 0 gives +32, 0x3f gives -31
	function automatic logic signed [6:0] analog_ppm(input logic [5:0] code);
		analog_ppm = ANALOG_ZERO_CODE - $signed({1'b0, code});
	endfunction : analog_ppm

	// Digital code to signed ppm; code 00 is disabled and adds nothing
	function automatic logic signed [6:0] digital_ppm(input logic [1:0] code);
		case (code)
			2'h1: digital_ppm = DIGITAL_STEP_PPM;
			2'h3: digital_ppm = -DIGITAL_STEP_PPM;
			default: digital_ppm = 7'sh00;
		endcase
	endfunction : digital_ppm

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [1:0] initial_digital_trim; // Coarse initial trim
	logic [5:0] initial_analog_trim; // Fine initial trim
	logic [6:0] curvature; // Scaled curvature magnitude
	logic temp_sense_enable; // Sensing and correction on
	logic battery_temp_sense_enable; // Allowed in battery mode
	logic battery_sense_rate; // High selects the one-minute period
	logic [3:0] step_gain; // Analog step gain

	// Address decode
	wire hit_trim = (reg_addr_in == INITIAL_TRIM_OFFSET);
	wire hit_curv = (reg_addr_in == CURVATURE_OFFSET);
	wire hit_ctrl = (reg_addr_in == TEMP_COMP_CTRL_OFFSET);
	wire wr_trim = reg_wr_in && hit_trim;
	wire wr_curv = reg_wr_in && hit_curv;
	wire wr_ctrl = reg_wr_in && hit_ctrl;

	// Software is trusted to change the trim fields only while sensing is
	// off; the writes are not blocked, so a mid-run change is stored at once and applied once correction stops
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			initial_digital_trim <= DIGITAL_TRIM_RESET;
			initial_analog_trim <= ANALOG_TRIM_RESET;
		end else if (wr_trim) begin
			initial_digital_trim <= reg_wdata_in[DIGITAL_TRIM_LSB +: 2];
			initial_analog_trim <= reg_wdata_in[ANALOG_TRIM_LSB +: 6];
		end
	end

	// Curvature register keeps only seven bits
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			curvature <= CURVATURE_RESET;
		end else if (wr_curv) begin
			curvature <= reg_wdata_in[6:0];
		end
	end

	// Control register; bit 4 has no storage
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			temp_sense_enable <= SENSE_EN_RESET;
			battery_temp_sense_enable <= BATT_SENSE_EN_RESET;
			battery_sense_rate <= BATT_RATE_RESET;
			step_gain <= STEP_GAIN_RESET;
		end else if (wr_ctrl) begin
			temp_sense_enable <= reg_wdata_in[SENSE_EN_BIT];
			battery_temp_sense_enable <= reg_wdata_in[BATT_SENSE_EN_BIT];
			battery_sense_rate <= reg_wdata_in[BATT_RATE_BIT];
			step_gain <= reg_wdata_in[STEP_GAIN_LSB +: 4];
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire [7:0] trim_view = {initial_digital_trim, initial_analog_trim};
	wire [7:0] curv_view = {1'b0, curvature};
	wire [7:0] ctrl_view = {temp_sense_enable, battery_temp_sense_enable,
		battery_sense_rate, 1'b0, step_gain};
	wire [7:0] next_rdata = hit_trim ? trim_view :
		hit_curv ? curv_view :
		hit_ctrl ? ctrl_view : 8'h00;

	// Read data is held until the next read strobe
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Compensation enable and battery pacing
	// ----------------------------------------------------------------
	// Battery mode needs its own enable and a healthy battery
	wire battery_ok = battery_temp_sense_enable && !vbat_low_in;
	wire next_comp_active = temp_sense_enable && (!on_battery_in || battery_ok);
	wire batt_run = temp_sense_enable && on_battery_in && battery_ok;
	logic batt_tick; // Period end from the pacing timer

	comp_period_timer #(
		.SLOW_CYC(SLOW_CYC),
		.FAST_CYC(FAST_CYC)
	) u_period (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.run_in(batt_run),
		.fast_in(battery_sense_rate),
		.tick_out(batt_tick)
	);

	assign convert_req_out = batt_tick;
	assign curvature_out = curvature;
	assign step_gain_out = step_gain;

	// ----------------------------------------------------------------
	// Trim selection
	// ----------------------------------------------------------------
	// Compensated values only while correction runs; otherwise initial ones.
	// Reverting to the initial trim in idle battery mode is deliberate.
	wire [5:0] next_analog = next_comp_active ? comp_analog_trim_in :
		initial_analog_trim;
	wire [1:0] next_digital = next_comp_active ? comp_digital_trim_in :
		initial_digital_trim;

	// Applied trim and decoded offsets are registered together
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			comp_active_out <= 1'b0;
			analog_trim_out <= ANALOG_TRIM_RESET;
			digital_trim_out <= DIGITAL_TRIM_RESET;
			analog_offset_ppm_out <= analog_ppm(ANALOG_TRIM_RESET);
			digital_offset_ppm_out <= digital_ppm(DIGITAL_TRIM_RESET);
			digital_trim_enable_out <= 1'b0;
		end else begin
			comp_active_out <= next_comp_active;
			analog_trim_out <= next_analog;
			digital_trim_out <= next_digital;
			analog_offset_ppm_out <= analog_ppm(next_analog);
			digital_offset_ppm_out <= digital_ppm(next_digital);
			digital_trim_enable_out <= (next_digital != 2'h0);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	sequence s_trim_write;
		wr_trim ##1 1'b1;
	endsequence

	a_trim_layout: assert property (s_trim_write |->
		initial_analog_trim == $past(reg_wdata_in[5:0]) &&
		initial_digital_trim == $past(reg_wdata_in[7:6]))
		else $error("Initial trim fields misplaced");

	a_tse_reset: assert property (disable iff (1'b0)
		reset_in |=> !temp_sense_enable && !comp_active_out)
		else $error("Sense enable not cleared by reset");

	a_analog_ppm: assert property (
		(analog_trim_out == 6'h00 |-> analog_offset_ppm_out == 7'sd32) and
		(analog_trim_out == 6'h20 |-> analog_offset_ppm_out == 7'sd0) and
		(analog_trim_out == 6'h3f |-> analog_offset_ppm_out == -7'sd31))
		else $error("Analog offset decode wrong");

	a_digital_ppm: assert property (
		(digital_trim_out == 2'h1 |-> digital_offset_ppm_out == 7'sd32) and
		(digital_trim_out == 2'h3 |-> digital_offset_ppm_out == -7'sd32) and
		(digital_trim_out == 2'h2 |-> digital_trim_enable_out &&
			digital_offset_ppm_out == 7'sd0) and
		(digital_trim_out == 2'h0 |-> !digital_trim_enable_out))
		else $error("Digital offset decode wrong");

	a_init_direct: assert property (!temp_sense_enable |=>
		analog_trim_out == $past(initial_analog_trim) &&
		digital_trim_out == $past(initial_digital_trim))
		else $error("Initial trim not applied while disabled");

	a_comp_follow: assert property (temp_sense_enable && !on_battery_in |=>
		comp_active_out && analog_trim_out == $past(comp_analog_trim_in))
		else $error("Compensated trim not applied");

	a_batt_gate: assert property (on_battery_in && !battery_temp_sense_enable |->
		!convert_req_out ##1 !comp_active_out)
		else $error("Battery sensing ran while not enabled");

	a_batt_low: assert property (on_battery_in && vbat_low_in |->
		!convert_req_out ##1 !comp_active_out)
		else $error("Battery sensing ran on a low battery");

	a_unused_zero: assert property (
		reg_rd_in && (hit_curv || hit_ctrl) |=> !reg_rdata_out[7] || $past(hit_ctrl))
		else $error("Unused curvature bit read as one");

	a_ctrl_bit4: assert property (reg_rd_in && hit_ctrl |=> !reg_rdata_out[4])
		else $error("Unused control bit read as one");

endmodule : crystal_trim_temp_comp_ctrl

// ==== verilog/trim_ctrl_pkg.sv ====
// Package for the crystal trim and temperature compensation control block.
// Holds register offsets, field positions, reset values and timing constants.
// Assumes a 100 MHz system clock drives all logic that imports it.
package trim_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses of the serial register port)
	// ----------------------------------------------------------------
	localparam logic [7:0] INITIAL_TRIM_OFFSET = 8'h0b;
	localparam logic [7:0] CURVATURE_OFFSET = 8'h0c;
	localparam logic [7:0] TEMP_COMP_CTRL_OFFSET = 8'h0d;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DIGITAL_TRIM_LSB = 6; // Two bits, 7:6
	localparam int ANALOG_TRIM_LSB = 0; // Six bits, 5:0
	localparam int SENSE_EN_BIT = 7; // Temperature sense enable
	localparam int BATT_SENSE_EN_BIT = 6; // Battery-mode sense enable
	localparam int BATT_RATE_BIT = 5; // Battery sense rate
	localparam int STEP_GAIN_LSB = 0; // Four bits, 3:0

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [1:0] DIGITAL_TRIM_RESET = 2'h0; // Digital trim disabled
	localparam logic [5:0] ANALOG_TRIM_RESET = 6'h20; // 0 ppm
	localparam logic [6:0] CURVATURE_RESET = 7'h00;
	localparam logic [3:0] STEP_GAIN_RESET = 4'h8; // Unity step size
	localparam logic SENSE_EN_RESET = 1'b0;
	localparam logic BATT_SENSE_EN_RESET = 1'b0;
	localparam logic BATT_RATE_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Trim decode constants
	// ----------------------------------------------------------------
	localparam logic signed [6:0] ANALOG_ZERO_CODE = 7'sh20; // Code giving 0 ppm
	localparam logic signed [6:0] DIGITAL_STEP_PPM = 7'sh20; // 32 ppm per step

	// ----------------------------------------------------------------
	// Timing: battery-mode compensation periods
	// ----------------------------------------------------------------
	localparam longint unsigned CLK_HZ = 100_000_000;
	localparam longint unsigned SLOW_PERIOD_S = 600; // Ten minutes
	localparam longint unsigned FAST_PERIOD_S = 60; // One minute
	localparam longint unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_S * CLK_HZ;
	localparam longint unsigned FAST_PERIOD_CYC = FAST_PERIOD_S * CLK_HZ;
	localparam int PERIOD_CNT_W = 40; // Enough for ten minutes at 100 MHz

endpackage : trim_ctrl_pkg

// ==== verilog/comp_period_timer.sv ====
// Period timer that paces battery-mode compensation cycles.
// Assumes run_in and fast_in are synchronous to mclk_in.
`timescale 1ns/1ns

module comp_period_timer import trim_ctrl_pkg::*; #(
	parameter longint unsigned SLOW_CYC = SLOW_PERIOD_CYC,
	parameter longint unsigned FAST_CYC = FAST_PERIOD_CYC
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic run_in, // Count while high
	input wire logic fast_in, // High selects the short period
	output logic tick_out // One-cycle pulse at each period end
);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	logic [PERIOD_CNT_W-1:0] count; // Cycles since last period start
	logic fast_q; // Rate seen last cycle
	wire [PERIOD_CNT_W-1:0] term_count = fast_in ? PERIOD_CNT_W'(FAST_CYC - 1) :
		PERIOD_CNT_W'(SLOW_CYC - 1);
	wire restart = !run_in || (fast_in != fast_q);
	wire at_term = (count == term_count);

	assign tick_out = run_in && !restart && at_term;

	// Restart on a rate change so a stale long count never overshoots
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			count <= '0;
			fast_q <= 1'b0;
		end else begin
			fast_q <= fast_in;
			if (restart || at_term) begin
				count <= '0;
			end else begin
				count <= count + PERIOD_CNT_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_fast_bound: assert property (@(posedge mclk_in) disable iff (reset_in)
		run_in && fast_in && fast_q |-> count <= PERIOD_CNT_W'(FAST_CYC - 1))
		else $error("Timer count passed the short period");

endmodule : comp_period_timer

// ==== verif/tb.sv ====
// Self-checking bench for the crystal trim and compensation control block.
// Drives the register strobe port and the battery and compensation inputs directly;
// the design's own assertions watch the logic during the run.
`timescale 1ns/1ns

module tb import trim_ctrl_pkg::*; ();
	// ----------------------------------------------------------------
	// Short periods keep the battery pacing runs brief
	// ----------------------------------------------------------------
	localparam longint unsigned FAST = 8; // Short period in cycles
	localparam longint unsigned SLOW = 40; // Long period in cycles

	logic mclk_in; // System clock
	logic reset_in; // Synchronous reset
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out; // Register port
	logic reg_wr_in, reg_rd_in; // Strobes
	logic on_battery_in, vbat_low_in; // Supply state
	logic [5:0] comp_analog_trim_in, analog_trim_out; // Analog trims
	logic [1:0] comp_digital_trim_in, digital_trim_out; // Digital trims
	logic comp_active_out, convert_req_out, digital_trim_enable_out; // Status
	logic [6:0] curvature_out; // Coefficient
	logic [3:0] step_gain_out; // Gain field
	logic signed [6:0] analog_offset_ppm_out, digital_offset_ppm_out; // Offsets
	int n_fail = 0; // Mismatches
	int tests_run = 0; // Comparisons
	int n; // Measured gap or pulse count
	logic [5:0] ana_tbl [4] = '{6'h00, 6'h20, 6'h3f, 6'h15}; // Boundary codes and mid-range 0x15

	crystal_trim_temp_comp_ctrl #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) crystal_trim_temp_comp_ctrl_inst (
		.mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .on_battery_in(on_battery_in),
		.vbat_low_in(vbat_low_in), .comp_analog_trim_in(comp_analog_trim_in),
		.comp_digital_trim_in(comp_digital_trim_in), .comp_active_out(comp_active_out),
		.convert_req_out(convert_req_out), .curvature_out(curvature_out),
		.step_gain_out(step_gain_out), .analog_trim_out(analog_trim_out),
		.digital_trim_out(digital_trim_out), .analog_offset_ppm_out(analog_offset_ppm_out),
		.digital_offset_ppm_out(digital_offset_ppm_out),
		.digital_trim_enable_out(digital_trim_enable_out)
	);

	// ----------------------------------------------------------------
	// Clock, 10 ns period
	// ----------------------------------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Compare and count; an unknown bit matches only the same unknown value
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Report the counts, give the verdict and end the run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	// Hold reset for ten edges, release on an edge
	task automatic do_reset();
		@(posedge mclk_in);
		reset_in <= 1'b1;
		repeat (10) @(posedge mclk_in);
		reset_in <= 1'b0;
	endtask : do_reset

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data is taken once the answering edge has landed
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata_out, exp);
	endtask : rchk

	// Let registered outputs follow a level change
	task automatic settle();
		repeat (3) @(posedge mclk_in);
		#1;
	endtask : settle

	// Applied trim codes and their ppm meaning
	task automatic trim_chk(input logic [5:0] a, input logic [1:0] dg);
		logic [6:0] e_ana;
		logic [6:0] e_dig;
		e_ana = 7'h20 - {1'b0, a};
		e_dig = (dg == 2'h1) ? 7'h20 : ((dg == 2'h3) ? 7'h60 : 7'h00);
		check("analog_trim", analog_trim_out, a);
		check("digital_trim", digital_trim_out, dg);
		check("analog_ppm", {analog_offset_ppm_out}, e_ana);
		check("digital_ppm", {digital_offset_ppm_out}, e_dig);
		check("digital_en", digital_trim_enable_out, dg != 2'h0);
	endtask : trim_chk

	// Cycles until the next conversion pulse; bounded so a silent timer ends the run
	task automatic next_pulse(output int k);
		k = 0;
		do begin
			if (k == 200) begin
				n_fail++;
				stop_test();
			end
			k++;
			@(posedge mclk_in);
			#1;
		end while (convert_req_out !== 1'b1);
	endtask : next_pulse

	// Pulses seen over a fixed stretch
	task automatic count_pulses(input int len, output int c);
		c = 0;
		repeat (len) begin
			@(posedge mclk_in);
			#1;
			c += (convert_req_out === 1'b1) ? 1 : 0;
		end
	endtask : count_pulses

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_in = 1'b1;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		on_battery_in = 1'b0;
		vbat_low_in = 1'b0;
		comp_analog_trim_in = 6'h00;
		comp_digital_trim_in = 2'h0;
		do_reset();
		// Values after power up
		rchk(INITIAL_TRIM_OFFSET, 8'h20);
		rchk(CURVATURE_OFFSET, 8'h00);
		rchk(TEMP_COMP_CTRL_OFFSET, 8'h08);
		settle();
		check("comp_active", comp_active_out, 1'b0);
		trim_chk(6'h20, 2'h0);
		// Every digital code with the analog codes in ana_tbl, sensing off
		for (int i = 0; i < 4; i++) begin
			wr(INITIAL_TRIM_OFFSET, {i[1:0], ana_tbl[i]});
			settle();
			trim_chk(ana_tbl[i], i[1:0]);
			rchk(INITIAL_TRIM_OFFSET, {i[1:0], ana_tbl[i]});
		end
		// Coefficient top bit never sticks; 35 is a typical scaled value
		wr(CURVATURE_OFFSET, 8'hff);
		rchk(CURVATURE_OFFSET, 8'h7f);
		wr(CURVATURE_OFFSET, 8'h23);
		#1;
		check("curvature", curvature_out, 7'h23);
		// Unused control bit and an unmapped offset
		wr(TEMP_COMP_CTRL_OFFSET, 8'h1c);
		rchk(TEMP_COMP_CTRL_OFFSET, 8'h0c);
		check("step_gain", step_gain_out, 4'hc);
		wr(8'h0e, 8'hff);
		rchk(8'h0e, 8'h00);
		rchk(INITIAL_TRIM_OFFSET, 8'hd5);
		// Sensing on, mains power: gain loaded while off, repeated with the enable
		wr(TEMP_COMP_CTRL_OFFSET, 8'h0a);
		@(posedge mclk_in);
		comp_analog_trim_in <= 6'h2a;
		comp_digital_trim_in <= 2'h1;
		wr(TEMP_COMP_CTRL_OFFSET, 8'h8a);
		settle();
		check("comp_active", comp_active_out, 1'b1);
		trim_chk(6'h2a, 2'h1);
		check("step_gain", step_gain_out, 4'ha);
		check("curvature", curvature_out, 7'h23);
		// Battery without battery sensing: no conversions, initial trim
		@(posedge mclk_in);
		on_battery_in <= 1'b1;
		settle();
		check("comp_active", comp_active_out, 1'b0);
		trim_chk(6'h15, 2'h3);
		count_pulses(60, n);
		check("pulses_off", n, 0);
		// Battery sensing at the fast rate, then the slow rate
		wr(TEMP_COMP_CTRL_OFFSET, 8'hea);
		settle();
		check("comp_active", comp_active_out, 1'b1);
		next_pulse(n);
		next_pulse(n);
		check("fast_gap", n, 32'(FAST));
		wr(TEMP_COMP_CTRL_OFFSET, 8'hca);
		next_pulse(n);
		next_pulse(n);
		check("slow_gap", n, 32'(SLOW));
		// Low battery blocks sensing whatever the enable says
		@(posedge mclk_in);
		vbat_low_in <= 1'b1;
		settle();
		check("comp_active", comp_active_out, 1'b0);
		count_pulses(100, n);
		check("pulses_low", n, 0);
		// Reset in mid-run clears the enable again
		do_reset();
		rchk(TEMP_COMP_CTRL_OFFSET, 8'h08);
		check("comp_active", comp_active_out, 1'b0);
		stop_test();
	end
endmodule : tb
